// *** ivm_pkg.sv ***
// Package with vector map constants and carrier types for the interrupt vector map.
package ivm_pkg;
	// ****************************************************************
	// Vector numbers and table layout
	// ****************************************************************
	localparam int VEC_W = 8;
	localparam int LVL_W = 5;
	localparam int LVL_IDX_W = 6;
	localparam int NUM_LVL_REGS = 48;
	localparam logic [31:0] TABLE_BASE_RST = 32'h000F_FC00;
	localparam logic [31:0] TABLE_TOP_OFFSET = 32'h0000_03FC;
	localparam logic [VEC_W-1:0] VEC_NMI = 8'h0F;
	localparam logic [VEC_W-1:0] VEC_FIRST_MASKABLE = 8'h10;
	localparam logic [VEC_W-1:0] VEC_TIMEBASE = 8'h2F;
	localparam logic [VEC_W-1:0] VEC_DELAYED = 8'h3F;
	localparam logic [VEC_W-1:0] VEC_OS_LO = 8'h40;
	localparam logic [VEC_W-1:0] VEC_OS_HI = 8'h41;
	localparam logic [VEC_W-1:0] VEC_TRAP_FIRST = 8'h50;
	localparam logic [LVL_W-1:0] LVL_NMI = 5'h0F;
	localparam logic [LVL_W-1:0] LVL_NONE = 5'h1F;

	// ****************************************************************
	// Carrier types
	// ****************************************************************
	typedef enum logic [1:0] {
		IVM_CLS_FIXED,
		IVM_CLS_MASKABLE,
		IVM_CLS_OS,
		IVM_CLS_TRAP
	} ivm_class_t;

	typedef struct packed {
		logic valid;
		logic [VEC_W-1:0] vec;
		logic [31:0] addr;
		logic [LVL_W-1:0] level;
		logic has_level;
		logic [LVL_IDX_W-1:0] lvl_idx;
		ivm_class_t cls;
	} ivm_fetch_t;
endpackage : ivm_pkg

// *** ivm_level_sel.sv ***
// Selects the priority level register that belongs to a vector number.
`timescale 1ns/1ps
`default_nettype none
module ivm_level_sel
	import ivm_pkg::*;
#(
	parameter int NUM_REGS = NUM_LVL_REGS
) (
	input wire logic [VEC_W-1:0] vec_in, // Vector number
	input wire logic [NUM_REGS*LVL_W-1:0] levels_in, // Flat level register set
	output logic has_level_out, // Vector owns a level register
	output logic [LVL_IDX_W-1:0] idx_out, // Level register index
	output logic [LVL_W-1:0] level_out // Level for the vector
);
	wire logic [VEC_W-1:0] rel_w;
	wire logic in_range_w;
	wire logic is_nmi_w;
	wire logic [LVL_W-1:0] picked_w;

	assign rel_w = vec_in - VEC_FIRST_MASKABLE;
	assign in_range_w = (vec_in >= VEC_FIRST_MASKABLE) && (rel_w < NUM_REGS[VEC_W-1:0]);
	assign is_nmi_w = (vec_in == VEC_NMI);
	assign picked_w = levels_in[rel_w[LVL_IDX_W-1:0]*LVL_W +: LVL_W];
	assign has_level_out = in_range_w; // R6
	assign idx_out = in_range_w ? rel_w[LVL_IDX_W-1:0] : '0;
	assign level_out = in_range_w ? picked_w : (is_nmi_w ? LVL_NMI : LVL_NONE); // R6
endmodule : ivm_level_sel
`default_nettype wire

// *** ivm_vector_map.sv ***
// Interrupt vector map: vector number to handler fetch address and level.
// Operation
// [R1] Handler address is table base plus 0x3FC minus four times vector number.
// [R2] Vectors 80 to 255 have no source or level; only trap instruction reaches.
// [R3] Delayed-interrupt source raises vector 63 with the last level register.
// [R4] Time-base timer overflow raises vector 47 with level register 31.
// [R5] Vectors 64 and 65 are kept for the OS, no level register.
// [R6] Vectors 16-63 use level register n-16; 0-14 none; NMI fixed level 15.
`timescale 1ns/1ps
`default_nettype none
module ivm_vector_map
	import ivm_pkg::*;
#(
	parameter int NUM_REGS = NUM_LVL_REGS
) (
	input wire logic ref_clk_in, // CPU clock
	input wire logic reset_n_in, // Asynchronous reset, active low
	input wire logic [31:0] vector_table_base_in, // Table base register value
	input wire logic [NUM_REGS*LVL_W-1:0] source_level_setting_in, // Level registers
	input wire logic take_in, // CPU takes a hardware exception
	input wire logic [VEC_W-1:0] take_vec_in, // Hardware vector number
	input wire logic trap_in, // Software trap instruction
	input wire logic [VEC_W-1:0] trap_vec_in, // Vector named by the trap
	input wire logic timebase_ovf_in, // Time-base timer overflow
	input wire logic delayed_irq_in, // Delayed-interrupt source bit
	output var ivm_fetch_t fetch_out, // Registered fetch request
	output logic reject_out, // Hardware request on trap-only vector
	output logic [VEC_W-1:0] src_vec_out, // Vector raised by a mapped source
	output logic src_req_out, // A mapped source is requesting
	output logic [LVL_W-1:0] src_level_out // Level of that source
);
	// ****************************************************************
	// Address and class decoding
	// ****************************************************************
	function automatic logic [31:0] vec_addr(input logic [31:0] base, input logic [VEC_W-1:0] v);
		vec_addr = base + TABLE_TOP_OFFSET - {22'd0, v, 2'b00}; // R1
	endfunction : vec_addr

	function automatic ivm_class_t vec_class(input logic [VEC_W-1:0] v);
		if (v >= VEC_TRAP_FIRST)
			vec_class = IVM_CLS_TRAP; // R2
		else if (v == VEC_OS_LO || v == VEC_OS_HI)
			vec_class = IVM_CLS_OS; // R5
		else if (v >= VEC_FIRST_MASKABLE && v <= VEC_DELAYED)
			vec_class = IVM_CLS_MASKABLE;
		else
			vec_class = IVM_CLS_FIXED;
	endfunction : vec_class

	// Software traps win over a hardware take in the same cycle; the core never issues both.
	wire logic [VEC_W-1:0] sel_vec_w;
	wire logic hw_bad_w;
	wire logic accept_w;
	wire logic has_lvl_w;
	wire logic [LVL_IDX_W-1:0] idx_w;
	wire logic [LVL_W-1:0] lvl_w;
	wire logic [LVL_W-1:0] src_lvl_w;
	wire ivm_fetch_t fetch_nxt;

	assign sel_vec_w = trap_in ? trap_vec_in : take_vec_in;
	assign hw_bad_w = !trap_in && take_in && (vec_class(take_vec_in) == IVM_CLS_TRAP); // R2
	assign accept_w = trap_in || (take_in && !hw_bad_w);

	ivm_level_sel #(.NUM_REGS(NUM_REGS)) u_sel (
		.vec_in(sel_vec_w),
		.levels_in(source_level_setting_in),
		.has_level_out(has_lvl_w),
		.idx_out(idx_w),
		.level_out(lvl_w)
	);

	assign fetch_nxt.valid = accept_w;
	assign fetch_nxt.vec = sel_vec_w;
	assign fetch_nxt.addr = vec_addr(vector_table_base_in, sel_vec_w); // R1
	assign fetch_nxt.level = lvl_w;
	assign fetch_nxt.has_level = has_lvl_w;
	assign fetch_nxt.lvl_idx = idx_w;
	assign fetch_nxt.cls = vec_class(sel_vec_w);

	// ****************************************************************
	// Mapped sources
	// ****************************************************************
	// The delayed interrupt is the OS task switch; it outranks the timer here.
	assign src_req_out = delayed_irq_in || timebase_ovf_in;
	assign src_vec_out = delayed_irq_in ? VEC_DELAYED : (timebase_ovf_in ? VEC_TIMEBASE : '0); // R3 R4
	assign src_lvl_w = delayed_irq_in
		? source_level_setting_in[(int'(VEC_DELAYED - VEC_FIRST_MASKABLE))*LVL_W +: LVL_W] // R3
		: source_level_setting_in[(int'(VEC_TIMEBASE - VEC_FIRST_MASKABLE))*LVL_W +: LVL_W]; // R4
	assign src_level_out = src_req_out ? src_lvl_w : LVL_NONE;

	// ****************************************************************
	// Output register
	// ****************************************************************
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			fetch_out <= '0;
			reject_out <= 1'b0;
		end else begin
			fetch_out <= fetch_nxt;
			reject_out <= hw_bad_w;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_fetch_addr: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R1
		accept_w |=> fetch_out.addr == $past(vector_table_base_in) + 32'h0000_03FC
			- {22'd0, $past(sel_vec_w), 2'b00})
		else $error("Fetch address does not match vector number");
	a_trap_only_range: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R2
		(take_in && !trap_in && take_vec_in >= 8'h50) |=> reject_out && !fetch_out.valid)
		else $error("Hardware request on trap-only vector accepted");
	a_trap_no_level: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R2
		(fetch_out.valid && fetch_out.vec >= 8'h50) |-> !fetch_out.has_level)
		else $error("Trap vector has a level register");
	a_delayed_vec: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R3
		delayed_irq_in |-> src_vec_out == 8'h3F && src_level_out == source_level_setting_in[239:235])
		else $error("Delayed interrupt not on vector 63 with last level");
	a_timebase_vec: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R4
		(timebase_ovf_in && !delayed_irq_in) |->
			src_vec_out == 8'h2F && src_level_out == source_level_setting_in[159:155])
		else $error("Time-base overflow not on vector 47 with level 31");
	a_os_reserved: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R5
		(accept_w && (sel_vec_w == 8'h40 || sel_vec_w == 8'h41)) |=>
			!fetch_out.has_level && fetch_out.cls == IVM_CLS_OS)
		else $error("OS vector has a level register");
	a_level_index: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R6
		(accept_w && sel_vec_w inside {[8'h10:8'h3F]}) |=>
			fetch_out.has_level && fetch_out.lvl_idx == 6'($past(sel_vec_w) - 8'h10))
		else $error("Maskable vector level index wrong");
	a_nmi_level: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R6
		(accept_w && sel_vec_w == 8'h0F) |=> fetch_out.level == 5'h0F && !fetch_out.has_level)
		else $error("NMI level is not 15");

	// Level register positions that the fetch checks for vectors 47 and 63 look at.
	localparam int TIMER_LVL_LSB = int'(VEC_TIMEBASE - VEC_FIRST_MASKABLE) * LVL_W;
	localparam int DELAYED_LVL_LSB = (NUM_REGS - 1) * LVL_W;

	// ****************************************************************
	// Sequences for multi-step checks
	// ****************************************************************
	// A hardware take that names a vector only a trap may reach.
	sequence s_hw_trap_range;
		take_in && !trap_in && (take_vec_in >= VEC_TRAP_FIRST);
	endsequence

	// The refusal as the core sees it on the next edge.
	sequence s_refused;
		reject_out && !fetch_out.valid;
	endsequence

	// Any request that the map accepts, trap or hardware.
	sequence s_accepted;
		accept_w;
	endsequence

	// The registered answer to an accepted request.
	sequence s_fetch_shown;
		fetch_out.valid && !reject_out;
	endsequence

	// Neither request line is raised.
	sequence s_no_request;
		!trap_in && !take_in;
	endsequence

	// Both mapped sources are quiet.
	sequence s_sources_idle;
		!delayed_irq_in && !timebase_ovf_in;
	endsequence

	// ****************************************************************
	// Handshake and class checks
	// ****************************************************************
	a_refuse_seq: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R2
		s_hw_trap_range |=> s_refused)
		else $error("Trap-only vector was not refused");
	a_accept_seq: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R1
		s_accepted |=> s_fetch_shown)
		else $error("Accepted request gave no fetch");
	a_idle_quiet: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R1
		s_no_request |=> !fetch_out.valid && !reject_out)
		else $error("Fetch or refusal without a request");
	a_reject_cause: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R2
		reject_out |-> $past(take_in) && !$past(trap_in))
		else $error("Refusal without a hardware take");
	a_trap_taken: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R2
		trap_in |=> fetch_out.valid && fetch_out.vec == $past(trap_vec_in))
		else $error("Trap instruction vector not fetched");
	a_trap_class: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R2
		(trap_in && trap_vec_in >= VEC_TRAP_FIRST) |=> fetch_out.cls == IVM_CLS_TRAP
			&& fetch_out.level == LVL_NONE)
		else $error("Trap-only vector not classed as trap");
	a_fetch_vec: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R1
		s_accepted |=> fetch_out.vec == $past(sel_vec_w))
		else $error("Fetched vector number differs from request");

	// ****************************************************************
	// Level register checks
	// ****************************************************************
	a_delayed_fetch: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R3
		(accept_w && sel_vec_w == VEC_DELAYED) |=> fetch_out.has_level
			&& fetch_out.lvl_idx == LVL_IDX_W'(NUM_REGS - 1)
			&& fetch_out.level == $past(source_level_setting_in[DELAYED_LVL_LSB +: LVL_W]))
		else $error("Delayed vector not on the last level register");
	a_timebase_fetch: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R4
		(accept_w && sel_vec_w == VEC_TIMEBASE) |=> fetch_out.has_level
			&& fetch_out.lvl_idx == LVL_IDX_W'(VEC_TIMEBASE - VEC_FIRST_MASKABLE)
			&& fetch_out.level == $past(source_level_setting_in[TIMER_LVL_LSB +: LVL_W]))
		else $error("Time-base vector not on its level register");
	a_os_no_level: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R5
		(accept_w && (sel_vec_w == VEC_OS_LO || sel_vec_w == VEC_OS_HI)) |=>
			fetch_out.level == LVL_NONE)
		else $error("OS vector shows a level");
	a_fixed_no_level: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R6
		(accept_w && sel_vec_w < VEC_NMI) |=> !fetch_out.has_level && fetch_out.level == LVL_NONE)
		else $error("Fixed vector shows a level register");

	// ****************************************************************
	// Mapped source checks
	// ****************************************************************
	a_src_priority: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R3
		(delayed_irq_in && timebase_ovf_in) |-> src_req_out && src_vec_out == VEC_DELAYED)
		else $error("Delayed interrupt lost to the timer");
	a_src_idle: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R4
		s_sources_idle |-> !src_req_out && src_vec_out == '0
			&& src_level_out == LVL_NONE)
		else $error("Source outputs not idle");
	a_src_request: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in) // R4
		(delayed_irq_in || timebase_ovf_in) |-> src_req_out)
		else $error("Mapped source not requesting");
endmodule : ivm_vector_map
`default_nettype wire

// *** ivm_cpu_model.sv ***
// CPU core model that takes handler fetches from the vector map.
`timescale 1ns/1ps
`default_nettype none
module ivm_cpu_model
	import ivm_pkg::*;
(
	input wire logic clk_in, // CPU clock
	input wire logic reset_n_in, // Asynchronous reset, active low
	input wire ivm_fetch_t fetch_in, // Fetch request from the map
	output logic [31:0] last_addr_out, // Last handler address fetched
	output logic [15:0] fetch_cnt_out // Fetches seen
);
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			last_addr_out <= 32'h0000_0000;
			fetch_cnt_out <= 16'h0000;
		end else if (fetch_in.valid) begin
			last_addr_out <= fetch_in.addr;
			fetch_cnt_out <= fetch_cnt_out + 16'h0001;
		end
	end
endmodule : ivm_cpu_model
`default_nettype wire

// *** tb.sv ***
// Self-checking testbench for the interrupt vector map.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ivm_pkg::*;
	logic ref_clk = 0, reset_n = 0, take = 0, trap = 0, tbo = 0, dly = 0, rej, sreq;
	logic [7:0] vec = 0, svec;
	logic [31:0] base = TABLE_BASE_RST, seed = 32'h0000_0014, last;
	logic [NUM_LVL_REGS*LVL_W-1:0] lv = '0;
	logic [4:0] slvl;
	logic [15:0] nf, nexp = 0;
	ivm_fetch_t f;
	int fail_count = 0, checks = 0, cyc = 0;
	logic [31:0] exp_last = 32'h0000_0000;
	logic [7:0] corner [9] = '{8'd0, 8'd15, 8'd16, 8'd47, 8'd63, 8'd64, 8'd65, 8'd80, 8'd255};
	ivm_vector_map i_dut (.ref_clk_in(ref_clk), .reset_n_in(reset_n), .vector_table_base_in(base),
		.source_level_setting_in(lv), .take_in(take), .take_vec_in(vec), .trap_in(trap),
		.trap_vec_in(vec), .timebase_ovf_in(tbo), .delayed_irq_in(dly), .fetch_out(f),
		.reject_out(rej), .src_vec_out(svec), .src_req_out(sreq), .src_level_out(slvl));
	ivm_cpu_model i_cpu (.clk_in(ref_clk), .reset_n_in(reset_n), .fetch_in(f),
		.last_addr_out(last), .fetch_cnt_out(nf));
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [4:0] lvl(input logic [7:0] v);
		if (v >= 16 && v < 64) return lv[5*(v-16)+:5];
		return (v == 15) ? LVL_NMI : LVL_NONE;
	endfunction : lvl
	function automatic logic [31:0] exp_addr(input logic [31:0] b, input logic [7:0] v);
		return b + TABLE_TOP_OFFSET - {22'd0, v, 2'b00};
	endfunction : exp_addr
	function automatic logic [1:0] exp_cls(input logic [7:0] v);
		if (v >= 80) return 2'd3;
		if (v == 64 || v == 65) return 2'd2;
		if (v >= 16 && v < 64) return 2'd1;
		return 2'd0;
	endfunction : exp_cls
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic op(input logic tr, input logic [7:0] v);
		@(posedge ref_clk);
		trap <= tr;
		take <= !tr;
		vec <= v;
		@(posedge ref_clk);
		trap <= 0;
		take <= 0;
		@(negedge ref_clk);
		if (tr || v < 80) begin
			nexp++;
			exp_last = exp_addr(base, v);
		end
		chk(f.addr, exp_addr(base, v));
		chk(f.vec, v);
	endtask : op
	task automatic cpu_chk();
		@(negedge ref_clk);
		chk(last, exp_last);
	endtask : cpu_chk
	task automatic take_chk(input logic [7:0] v);
		op(0, v);
		chk(rej, v >= 80);
		chk(f.valid, v < 80);
		if (v < 80) chk(f.level, lvl(v));
		if (v < 66) chk(f.cls, exp_cls(v));
		if (v != 15 && v < 80) chk(f.has_level, v >= 16 && v < 64);
		if (v >= 16 && v < 64) chk(f.lvl_idx, v - 8'd16);
		cpu_chk();
	endtask : take_chk
	task automatic trap_chk(input logic [7:0] v);
		op(1, v);
		chk(f.cls, exp_cls(v));
		chk({rej, f.valid}, 2'b01);
		chk(f.level, lvl(v));
		if (v >= 80) chk({f.has_level, f.level}, {1'b0, LVL_NONE});
		cpu_chk();
	endtask : trap_chk
	task automatic test_done();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : test_done
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			test_done();
		end
	end
	initial begin
		for (int k = 0; k < NUM_LVL_REGS; k++) lv[5*k+:5] <= 5'(rnd());
		repeat (16) @(posedge ref_clk);
		reset_n <= 1;
		foreach (corner[i]) take_chk(corner[i]);
		trap_chk(8'h50);
		trap_chk(8'hFF);
		trap_chk(8'h2F);
		$display("test corner done");
		@(posedge ref_clk);
		tbo <= 1;
		@(negedge ref_clk);
		chk({sreq, svec, slvl}, {1'b1, VEC_TIMEBASE, lv[5*31+:5]});
		@(posedge ref_clk);
		dly <= 1;
		@(negedge ref_clk);
		chk({sreq, svec, slvl}, {1'b1, VEC_DELAYED, lv[5*47+:5]});
		@(posedge ref_clk);
		tbo <= 0;
		@(negedge ref_clk);
		chk({sreq, svec, slvl}, {1'b1, VEC_DELAYED, lv[5*47+:5]});
		@(posedge ref_clk);
		dly <= 0;
		@(negedge ref_clk);
		chk({sreq, svec, slvl}, {1'b0, 8'h00, LVL_NONE});
		$display("test source done");
		for (int i = 0; i < 60; i++) begin
			@(posedge ref_clk);
			base <= rnd() & 32'hFFFF_FC00;
			if (i % 2) take_chk(8'(rnd() % 66));
			else trap_chk(8'(rnd()));
		end
		$display("test random done");
		chk(nf, nexp);
		test_done();
	end
endmodule : tb
`default_nettype wire
